// File: dram_command_pkg.sv
// Shared constants, encodings and types for the command decoder
package dram_command_pkg;

  // Bus widths and bank count
  localparam int CA_WIDTH = 6;
  localparam int BANK_WIDTH = 3;
  localparam int BANK_COUNT = 8;
  localparam int COLUMN_WIDTH = 10;
  localparam int OPCODE_WIDTH = 7;

  // First-half encodings of command_address_lines[4:0]
  localparam logic [4:0] FH_MULTI_PURPOSE = 5'h00;
  localparam logic [4:0] FH_PRECHARGE = 5'h10;
  localparam logic [4:0] FH_REFRESH = 5'h08;
  localparam logic [4:0] FH_SR_ENTRY = 5'h18;
  localparam logic [4:0] FH_WRITE = 5'h04;
  localparam logic [4:0] FH_SR_EXIT = 5'h14;
  localparam logic [4:0] FH_MASK_WRITE = 5'h0C;
  localparam logic [4:0] FH_READ = 5'h02;
  localparam logic [4:0] FH_CAS2 = 5'h12;
  localparam logic [4:0] FH_MODE_WRITE_1 = 5'h06;
  localparam logic [4:0] FH_MODE_WRITE_2 = 5'h16;
  localparam logic [4:0] FH_MODE_READ_1 = 5'h0E;
  localparam logic [1:0] FH_ACT1_LOW = 2'h1;
  localparam logic [1:0] FH_ACT2_LOW = 2'h3;

  // Field positions on the command/address lines
  localparam int FLAG_BIT = 5;
  localparam int C9_BIT = 4;
  localparam int AUTO_PRECHARGE_BIT = 5;

  // Deselect cycles owed after an oscillator or calibration multi-purpose command
  localparam logic [1:0] MULTI_PURPOSE_GAP_CYCLES = 2'h2;

  // Bank select values: reset, all banks and single bank
  localparam logic [BANK_COUNT-1:0] BANK_SELECT_RESET = 8'h00;
  localparam logic [BANK_COUNT-1:0] BANK_SELECT_ALL = 8'hFF;
  localparam logic [BANK_COUNT-1:0] BANK_SELECT_ONE = 8'h01;

  typedef enum logic [3:0] {
    cmd_none, cmd_multi_purpose, cmd_precharge, cmd_refresh, cmd_selfrefresh_entry,
    cmd_selfrefresh_exit, cmd_write, cmd_mask_write, cmd_read, cmd_cas2,
    cmd_mode_write_first_half, cmd_mode_write_second_half,
    cmd_mode_read_first_half, cmd_activate_first, cmd_activate_second, cmd_reserved
  } command_kind_t;

  typedef enum logic [2:0] {
    follow_none, follow_cas, follow_act2, follow_mrw2, follow_gap
  } follow_t;

  typedef enum logic {phase_first, phase_second} phase_t;

  // Decoded command, presented for one cycle with valid
  typedef struct packed {
    logic valid;
    command_kind_t kind;
    logic [BANK_WIDTH-1:0] bank;
    logic all_banks_flag;
    logic auto_precharge_flag;
    logic burst_32;
    logic [COLUMN_WIDTH-1:0] column;
    logic [OPCODE_WIDTH-1:0] opcode;
  } command_t;

  // Access held between its first command and the column command
  typedef struct packed {
    command_kind_t kind;
    logic [BANK_WIDTH-1:0] bank;
    logic column_bit9;
    logic auto_precharge_flag;
    logic burst_32;
  } access_t;

  // Pins that arrive from the controller's domain
  typedef struct packed {
    logic link_clock;
    logic chip_select;
    logic clock_enable;
    logic [CA_WIDTH-1:0] command_address_lines;
  } pins_t;

  // Classify a first half from CA[4:0]
  function automatic command_kind_t decode_first_half(input logic [4:0] ca);
    command_kind_t kind;
    kind = cmd_reserved;
    if (ca[1:0] == FH_ACT1_LOW) begin
      kind = cmd_activate_first;
    end else if (ca[1:0] == FH_ACT2_LOW) begin
      kind = cmd_activate_second;
    end else begin
      case (ca)
        FH_MULTI_PURPOSE: kind = cmd_multi_purpose;
        FH_PRECHARGE: kind = cmd_precharge;
        FH_REFRESH: kind = cmd_refresh;
        FH_SR_ENTRY: kind = cmd_selfrefresh_entry;
        FH_WRITE: kind = cmd_write;
        FH_SR_EXIT: kind = cmd_selfrefresh_exit;
        FH_MASK_WRITE: kind = cmd_mask_write;
        FH_READ: kind = cmd_read;
        FH_CAS2: kind = cmd_cas2;
        FH_MODE_WRITE_1: kind = cmd_mode_write_first_half;
        FH_MODE_WRITE_2: kind = cmd_mode_write_second_half;
        FH_MODE_READ_1: kind = cmd_mode_read_first_half;
        default: kind = cmd_reserved;
      endcase
    end
    return kind;
  endfunction

endpackage

// File: sync_two_stage.sv
// Two-flop synchroniser for a bundle of pins from another clock domain
`timescale 1ns/100ps
`default_nettype none
module sync_two_stage #(
  parameter int WIDTH = 1
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;

  // First stage feeds only the second
  always_comb begin
    next_stage1 = i_enable ? i_async : stage1;
    next_sync = i_enable ? stage1 : o_sync;
  end

  // Both stages clear on reset
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= next_stage1;
      o_sync <= next_sync;
    end
  end
endmodule // sync_two_stage
`default_nettype wire

// File: dram_command_decode_timing.sv
// Command decoder for a low-power DRAM channel, device side
// Summary of operation
// R1 - Commands take two link cycles, first identified by chip select high; deselect is one.
// R2 - Multi-purpose command: opcode bit6 in first half, bits 5..0 in second.
// R3 - Precharge and refresh carry the all-banks flag and bank number.
// R4 - Column command carries column bit8 first, column bits 7..2 second.
// R5 - Bank-addressed commands act only on the bank given in the second half.
// R6 - All-banks flag high selects every bank and ignores bank address.
// R7 - Controller uses masked write with burst 16 and CA5 low.
// R8 - Auto-precharge flag high precharges the addressed bank after the access.
// R9 - Burst select picks 32 or 16 when on-the-fly burst is enabled.
// R10 - Column bits 1..0 are zero; masked/normal write column bits 3..2 low.
// R11 - Any unspecified operation is illegal until reset and reinitialisation.
// R12 - Controller holds clock enable each level for max(7.5 ns, 4 cycles).
// R13 - Controller waits max(1.75 ns, 3 cycles) after a command before power-down.
// R14 - Controller waits max(7.5 ns, 5 cycles) after power-down exit.
// R15 - Chip select stays valid around clock-enable low by given margins.
// R16 - Dual delays expire only when both time and cycle count pass.
// R17 - Oscillator readout waits max(40 ns, 8 cycles) after stop.
// R18 - FIFO write command waits row-to-column delay plus 3 cycles after exit.
// R19 - Clock stays valid max(7.5 ns, 4 cycles) around set point change.
// R20 - Set point switching takes 200 ns or 250 ns before use.
// R21 - Activate timings grow by 1.875 ns or 3.75 ns from 85 to 95 degrees.
// R22 - Defined-level fields must be high or low; don't-care fields may float.
// R23 - First-half activate is followed at once by its second half.
// R24 - First-half mode write is followed at once by its second half.
// R25 - Access commands need the column command next; other multi-purpose commands need two deselects.
`timescale 1ns/100ps
`default_nettype none
module dram_command_decode_timing
  import dram_command_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_link_clock,
  input wire logic i_chip_select,
  input wire logic i_clock_enable,
  input wire logic [CA_WIDTH-1:0] i_command_address_lines,
  input wire logic i_burst_on_the_fly,
  input wire logic i_default_burst_32,
  output var command_t o_command,
  output logic [BANK_COUNT-1:0] o_bank_select,
  output logic o_illegal,
  output logic o_powered_down
);
  pins_t pins_raw;
  pins_t pins;
  logic link_delayed;
  logic link_edge;
  logic step;
  phase_t phase;
  follow_t follow;
  command_kind_t kind_latched;
  logic flag_latched;
  access_t access;
  logic [1:0] gap;
  logic fault;
  logic [CA_WIDTH-1:0] ca;
  phase_t next_phase;
  follow_t next_follow;
  command_kind_t next_kind;
  logic next_flag;
  access_t next_access;
  logic [1:0] next_gap;
  command_t next_command;
  logic [BANK_COUNT-1:0] next_bank_select;
  logic next_illegal;
  logic next_powered_down;
  logic next_link_delayed;
  command_kind_t first_kind;

  // All controller pins cross as one bundle; the link clock is slow enough
  // that CS and CA have long settled when its synchronised edge is seen
  assign pins_raw = '{link_clock: i_link_clock, chip_select: i_chip_select,
                      clock_enable: i_clock_enable, command_address_lines: i_command_address_lines};

  sync_two_stage #(
    .WIDTH($bits(pins_t))
  ) pin_sync (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_enable(i_enable),
    .i_async(pins_raw),
    .o_sync(pins)
  );

  // Rising link edge; commands are only taken while clock enable is high
  assign link_edge = pins.link_clock & ~link_delayed;
  assign step = link_edge & i_enable & pins.clock_enable;
  assign ca = pins.command_address_lines;
  assign first_kind = decode_first_half(ca[4:0]);

  // Command sequencing and field extraction
  always_comb begin
    next_phase = phase;
    next_follow = follow;
    next_kind = kind_latched;
    next_flag = flag_latched;
    next_access = access;
    next_gap = gap;
    next_command = o_command;
    next_command.valid = 1'b0;
    next_bank_select = o_bank_select;
    next_link_delayed = i_enable ? pins.link_clock : link_delayed;
    next_powered_down = i_enable ? ~pins.clock_enable : o_powered_down;
    fault = 1'b0;
    if (step && phase == phase_first) begin
      if (!pins.chip_select) begin
        // Deselect is a single cycle and emits nothing [R1]
        if (follow == follow_gap) begin
          next_gap = gap - 2'h1;
          if (gap == 2'h1) begin
            next_follow = follow_none;
          end
        end else if (follow != follow_none) begin
          fault = 1'b1; // [R23] [R24] [R25]
          next_follow = follow_none;
        end
      end else begin
        // First half: kind from CA[4:0], CA5 kept for the second half [R1]
        next_kind = first_kind;
        next_flag = ca[FLAG_BIT];
        next_phase = phase_second;
        next_follow = follow_none;
        case (follow)
          follow_cas: fault = (first_kind != cmd_cas2); // [R25]
          follow_act2: fault = (first_kind != cmd_activate_second); // [R23]
          follow_mrw2: fault = (first_kind != cmd_mode_write_second_half); // [R24]
          follow_gap: fault = (first_kind != cmd_cas2) && (gap != 2'h0); // [R25]
          follow_none: fault = (first_kind == cmd_cas2) || (first_kind == cmd_activate_second)
                               || (first_kind == cmd_mode_write_second_half); // [R23] [R24]
          default: fault = 1'b1;
        endcase
        // Reserved codes and masked write with CA5 high are illegal [R11] [R7]
        if (first_kind == cmd_reserved || (first_kind == cmd_mask_write && ca[FLAG_BIT])) begin
          fault = 1'b1;
        end
      end
    end else if (step) begin
      next_phase = phase_first;
      if (pins.chip_select) begin
        fault = 1'b1; // Second half must have CS low [R1] [R11]
      end else begin
        next_command = '0;
        next_command.valid = 1'b1;
        next_command.kind = kind_latched;
        // Unused V fields are passed raw and never steer behaviour [R22]
        next_command.opcode = {flag_latched, ca}; // [R2]
        case (kind_latched)
          cmd_multi_purpose: begin
            next_follow = follow_gap; // [R25]
            next_gap = MULTI_PURPOSE_GAP_CYCLES;
            next_access = '{cmd_multi_purpose, '0, 1'b0, 1'b0, 1'b0};
          end
          cmd_precharge, cmd_refresh: begin
            next_command.bank = ca[BANK_WIDTH-1:0]; // [R3]
            next_command.all_banks_flag = flag_latched; // [R3]
            // All banks overrides the bank field [R6], else only the named bank [R5]
            next_bank_select = flag_latched ? BANK_SELECT_ALL
                               : BANK_SELECT_ONE << ca[BANK_WIDTH-1:0];
          end
          cmd_write, cmd_mask_write, cmd_read: begin
            // Held until the column command completes the access
            next_command.valid = 1'b0;
            next_follow = follow_cas; // [R25]
            next_access.kind = kind_latched;
            next_access.bank = ca[BANK_WIDTH-1:0];
            next_access.column_bit9 = ca[C9_BIT];
            next_access.auto_precharge_flag = ca[AUTO_PRECHARGE_BIT];
            // Masked write is burst 16 only [R7]; otherwise on-the-fly or default [R9]
            next_access.burst_32 = (kind_latched != cmd_mask_write)
                                   && (i_burst_on_the_fly ? flag_latched : i_default_burst_32);
          end
          cmd_mode_read_first_half: begin
            next_follow = follow_cas; // [R25]
            next_access = '{cmd_mode_read_first_half, '0, 1'b0, 1'b0, 1'b0};
          end
          cmd_cas2: begin
            next_command.kind = access.kind;
            next_command.bank = access.bank;
            next_command.auto_precharge_flag = access.auto_precharge_flag; // [R8]
            next_command.burst_32 = access.burst_32; // [R9]
            // Column bits 9, 8, 7..2 and two zero low bits [R4] [R10]
            next_command.column = {access.column_bit9, flag_latched, ca, 2'b00};
            next_access.kind = cmd_none;
            if (access.kind == cmd_write || access.kind == cmd_mask_write
                || access.kind == cmd_read) begin
              next_bank_select = BANK_SELECT_ONE << access.bank; // [R5]
            end
            if ((access.kind == cmd_write || access.kind == cmd_mask_write) && ca[1:0] != 2'b00) begin
              fault = 1'b1; // Column bits 3..2 must be low on writes [R10]
            end
          end
          cmd_mode_write_first_half: next_follow = follow_mrw2; // [R24]
          cmd_activate_first: begin
            next_follow = follow_act2; // [R23]
            next_command.bank = ca[BANK_WIDTH-1:0];
          end
          default: next_follow = follow_none;
        endcase
      end
    end
    // Sticky until reset; nothing clears it in operation [R11]
    next_illegal = o_illegal | fault;
  end

  // Register the decoder state
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      phase <= phase_first;
      follow <= follow_none;
      kind_latched <= cmd_none;
      flag_latched <= 1'b0;
      access <= '0;
      gap <= 2'h0;
      o_command <= '0;
      o_bank_select <= BANK_SELECT_RESET;
      o_illegal <= 1'b0;
      o_powered_down <= 1'b1;
      link_delayed <= 1'b0;
    end else if (i_enable) begin
      phase <= next_phase;
      follow <= next_follow;
      kind_latched <= next_kind;
      flag_latched <= next_flag;
      access <= next_access;
      gap <= next_gap;
      o_command <= next_command;
      o_bank_select <= next_bank_select;
      o_illegal <= next_illegal;
      o_powered_down <= next_powered_down;
      link_delayed <= next_link_delayed;
    end else begin
      o_command.valid <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_multi_purpose_first;
    step && phase == phase_first && pins.chip_select && ca[4:0] == FH_MULTI_PURPOSE;
  endsequence
  sequence s_multi_purpose_second;
    step && phase == phase_second && !pins.chip_select && kind_latched == cmd_multi_purpose;
  endsequence

  property p_multi_purpose_two_step;
    s_multi_purpose_first ##[1:40] s_multi_purpose_second
      |=> o_command.valid && o_command.kind == cmd_multi_purpose;
  endproperty
  a_multi_purpose_two_step: assert property (p_multi_purpose_two_step) else $error("command lost"); // [R1] [R2]

  property p_deselect_silent;
    step && phase == phase_first && !pins.chip_select |=> !o_command.valid;
  endproperty
  a_deselect_silent: assert property (p_deselect_silent) else $error("deselect emitted"); // [R1]

  property p_multi_purpose_opcode;
    s_multi_purpose_second |=> o_command.opcode == {$past(flag_latched), $past(ca)};
  endproperty
  a_multi_purpose_opcode: assert property (p_multi_purpose_opcode) else $error("opcode wrong"); // [R2]

  property p_all_banks;
    o_command.valid && o_command.all_banks_flag |-> o_bank_select == BANK_SELECT_ALL;
  endproperty
  a_all_banks: assert property (p_all_banks) else $error("all banks not selected"); // [R6]

  property p_one_bank;
    o_command.valid && !o_command.all_banks_flag
      && (o_command.kind == cmd_precharge || o_command.kind == cmd_read)
      |-> o_bank_select == (BANK_SELECT_ONE << o_command.bank);
  endproperty
  a_one_bank: assert property (p_one_bank) else $error("bank select wrong"); // [R5]

  property p_column_low;
    o_command.valid |-> o_command.column[1:0] == 2'b00;
  endproperty
  a_column_low: assert property (p_column_low) else $error("column low bits set"); // [R10]

  property p_mask_burst;
    o_command.valid && o_command.kind == cmd_mask_write |-> !o_command.burst_32;
  endproperty
  a_mask_burst: assert property (p_mask_burst) else $error("masked write not burst 16"); // [R7] [R9]

  property p_illegal_sticky;
    o_illegal |=> o_illegal;
  endproperty
  a_illegal_sticky: assert property (p_illegal_sticky) else $error("illegal flag cleared"); // [R11]

  property p_second_cs_high;
    step && phase == phase_second && pins.chip_select |=> o_illegal && !o_command.valid;
  endproperty
  a_second_cs_high: assert property (p_second_cs_high) else $error("bad second half missed"); // [R1]

  property p_auto_precharge;
    o_command.valid && o_command.auto_precharge_flag
      |-> o_command.kind inside {cmd_write, cmd_mask_write, cmd_read};
  endproperty
  a_auto_precharge: assert property (p_auto_precharge) else $error("stray auto precharge"); // [R8]

endmodule // dram_command_decode_timing
`default_nettype wire

// File: ctrl_link_model.sv
// Controller-side model that drives the command link pins of the decoder
`timescale 1ns/100ps
`default_nettype none
module ctrl_link_model (
  output logic o_link_clock,
  output logic o_chip_select,
  output logic o_clock_enable,
  output logic [5:0] o_command_address_lines
);
  localparam realtime HALF = 62.5;

  // Idle state: clock parked low, deselect, clock enable high
  initial begin
    o_link_clock = 1'b0;
    o_chip_select = 1'b0;
    o_clock_enable = 1'b1;
    o_command_address_lines = 6'h00;
  end

  // One link cycle; pins settle a half period before the rising edge and hold after it
  task automatic half(input logic [6:0] v);
    o_chip_select = v[6];
    o_command_address_lines = v[5:0];
    #HALF o_link_clock = 1'b1;
    #HALF o_link_clock = 1'b0;
  endtask

  // Released lines show the inverse so a stale value is never mistaken for a command;
  // the half period of rest keeps the next frame's drive out of this time step
  task automatic release_lines();
    o_chip_select = 1'b0;
    o_command_address_lines = ~o_command_address_lines;
    #HALF;
  endtask

  // Deselect cycles with the clock running, for spacing the controller owes
  task automatic idle(input int n);
    repeat (n) half(7'h00);
  endtask

  // Clock enable change framed by running clock and deselects on both sides
  task automatic set_cke(input logic v);
    repeat (5) half(7'h00);
    o_clock_enable = v;
    repeat (5) half(7'h00);
    release_lines();
  endtask
endmodule // ctrl_link_model
`default_nettype wire

// File: dram_command_decode_timing_tb_top.sv
// Self-checking bench for the command decoder against a controller model
`timescale 1ns/100ps
`default_nettype none
module dram_command_decode_timing_tb_top;
  import dram_command_pkg::*;
  typedef struct {int kind; int bank; int all_bank; int auto_pre; int b32; int col; int op;
    int bsel;} exp_t;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic burst_otf = 1'b1;
  logic burst_def = 1'b0;
  wire link_clock;
  wire chip_select;
  wire clock_enable;
  wire [CA_WIDTH-1:0] ca_lines;
  command_t o_command;
  logic [BANK_COUNT-1:0] o_bank_select;
  logic o_illegal;
  logic o_powered_down;
  int fails = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'h6B71;
  command_t got_q[$];
  logic [7:0] bsel_q[$];
  exp_t exp_q[$];
  command_kind_t ak[3] = '{cmd_write, cmd_mask_write, cmd_read};
  logic [4:0] af[3] = '{FH_WRITE, FH_MASK_WRITE, FH_READ};
  logic [6:0] bad[7][4] = '{'{7'h52, 7'h00, 7'h00, 7'h00}, '{7'h6C, 7'h00, 7'h52, 7'h00},
    '{7'h5E, 7'h00, 7'h00, 7'h00}, '{7'h41, 7'h00, 7'h44, 7'h00},
    '{7'h44, 7'h00, 7'h52, 7'h03}, '{7'h40, 7'h00, 7'h50, 7'h00},
    '{7'h40, 7'h40, 7'h00, 7'h00}};

  // System clock, 8 ns period
  always #4 i_clock = ~i_clock;

  dram_command_decode_timing dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_enable(1'b1),
    .i_link_clock(link_clock), .i_chip_select(chip_select), .i_clock_enable(clock_enable),
    .i_command_address_lines(ca_lines), .i_burst_on_the_fly(burst_otf),
    .i_default_burst_32(burst_def), .o_command(o_command), .o_bank_select(o_bank_select),
    .o_illegal(o_illegal), .o_powered_down(o_powered_down));

  ctrl_link_model ctrl (.o_link_clock(link_clock), .o_chip_select(chip_select),
    .o_clock_enable(clock_enable), .o_command_address_lines(ca_lines));

  // Capture every emitted command together with the bank select it left behind,
  // mid-cycle where the registered outputs have settled
  always @(negedge i_clock) begin
    if (i_rst_n === 1'b1 && o_command.valid === 1'b1) begin
      got_q.push_back(o_command);
      bsel_q.push_back(o_bank_select);
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A field of -1 is left unchecked
  task automatic cmp_field(input logic [31:0] got, input int exp);
    if (exp >= 0) begin
      cmp_count++;
      if (got !== exp[31:0]) begin
        fails++;
        $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
    end
  endtask

  task automatic cmp_level(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic expect_cmd(input int k, b, all_bank, auto_pre, b32, col, op, bs);
    exp_q.push_back('{k, b, all_bank, auto_pre, b32, col, op, bs});
  endtask

  task automatic frame(input logic [6:0] s[$]);
    foreach (s[i]) ctrl.half(s[i]);
    ctrl.release_lines();
  endtask

  // Pair each expected command with the next emitted one
  task automatic check_out();
    exp_t e;
    command_t g;
    for (int i = 0; i < 40 && got_q.size() < exp_q.size(); i++) @(negedge i_clock);
    repeat (4) @(negedge i_clock);
    cmp_level(8'(got_q.size()), 8'(exp_q.size()));
    while (exp_q.size() > 0 && got_q.size() > 0) begin
      e = exp_q.pop_front();
      g = got_q.pop_front();
      cmp_field(32'(g.kind), e.kind);
      cmp_field(32'(g.bank), e.bank);
      cmp_field(32'(g.all_banks_flag), e.all_bank);
      cmp_field(32'(g.auto_precharge_flag), e.auto_pre);
      cmp_field(32'(g.burst_32), e.b32);
      cmp_field(32'(g.column), e.col);
      cmp_field(32'(g.opcode), e.op);
      cmp_field(32'(bsel_q.pop_front()), e.bsel);
    end
    exp_q.delete();
    got_q.delete();
    bsel_q.delete();
  endtask

  // Synchronous reset for 16 cycles, then let the synchronisers settle
  task automatic do_reset();
    @(negedge i_clock);
    i_rst_n = 1'b0;
    repeat (16) @(negedge i_clock);
    i_rst_n = 1'b1;
    repeat (6) @(negedge i_clock);
    got_q.delete();
    bsel_q.delete();
  endtask

  // Watchdog: the whole sequence needs well under 60 us
  initial begin
    #300000;
    fails++;
    finish_test();
  end

  initial begin
    logic [31:0] r;
    logic [5:0] c72;
    int k;
    do_reset();
    cmp_level(8'(o_powered_down), 8'h00);
    // Multi-purpose commands followed by the two owed deselects
    repeat (3) begin
      r = rnd();
      frame('{{1'b1, r[6], FH_MULTI_PURPOSE}, {1'b0, r[5:0]}, 7'h00, 7'h00});
      expect_cmd(cmd_multi_purpose, -1, -1, -1, -1, -1, int'(r[6:0]), -1);
    end
    check_out();
    // Precharge and refresh, per bank and all banks
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      frame('{{1'b1, i[0], i[1] ? FH_REFRESH : FH_PRECHARGE}, {1'b0, r[5:0]}});
      expect_cmd(i[1] ? cmd_refresh : cmd_precharge, i[0] ? -1 : int'(r[2:0]), i[0], -1, -1,
        -1, -1, i[0] ? 255 : int'(8'h01 << r[2:0]));
    end
    check_out();
    // Write, masked write and read, with and without on-the-fly burst select
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      k = i % 3;
      @(negedge i_clock);
      burst_otf = (i < 3);
      burst_def = r[20];
      c72 = (k == 2) ? r[11:6] : {r[11:8], 2'b00};
      frame('{{1'b1, k == 1 ? 1'b0 : r[12], af[k]}, {1'b0, r[5:0]}, {1'b1, r[13], FH_CAS2},
        {1'b0, c72}});
      expect_cmd(ak[k], int'(r[2:0]), -1, int'(r[5]), k == 1 ? 0 : (i < 3 ? r[12] : r[20]),
        int'({r[4], r[13], c72, 2'b00}), -1, int'(8'h01 << r[2:0]));
    end
    check_out();
    // Paired commands and self refresh
    r = rnd();
    ctrl.idle(4);
    frame('{{1'b1, r[5:2], 2'b01}, {1'b0, r[11:6]}, {1'b1, r[15:12], 2'b11}, 7'h15});
    frame('{{1'b1, r[22], FH_MODE_WRITE_1}, {1'b0, r[5:0]}, {1'b1, r[23], FH_MODE_WRITE_2},
      {1'b0, r[11:6]}});
    ctrl.idle(8);
    frame('{{1'b1, 1'b0, FH_MODE_READ_1}, {1'b0, r[5:0]}, {1'b1, r[13], FH_CAS2},
      {1'b0, r[19:14]}});
    frame('{{1'b1, 1'b0, FH_SR_ENTRY}, 7'h00, {1'b1, 1'b0, FH_SR_EXIT}, 7'h00});
    expect_cmd(cmd_activate_first, -1, -1, -1, -1, -1, -1, -1);
    expect_cmd(cmd_activate_second, -1, -1, -1, -1, -1, -1, -1);
    expect_cmd(cmd_mode_write_first_half, -1, -1, -1, -1, -1, -1, -1);
    expect_cmd(cmd_mode_write_second_half, -1, -1, -1, -1, -1, -1, -1);
    expect_cmd(cmd_mode_read_first_half, -1, -1, -1, -1, -1, -1, -1);
    expect_cmd(cmd_mode_read_first_half, -1, -1, -1, -1, -1, -1, -1);
    expect_cmd(cmd_selfrefresh_entry, -1, -1, -1, -1, -1, -1, -1);
    expect_cmd(cmd_selfrefresh_exit, -1, -1, -1, -1, -1, -1, -1);
    check_out();
    cmp_level(8'(o_illegal), 8'h00);
    // Power-down: a command while clock enable is low is ignored
    ctrl.set_cke(1'b0);
    cmp_level(8'(o_powered_down), 8'h01);
    frame('{7'h40, 7'h2A, 7'h00, 7'h00});
    ctrl.set_cke(1'b1);
    cmp_level(8'(o_powered_down), 8'h00);
    ctrl.idle(4);
    frame('{7'h40, 7'h2A, 7'h00, 7'h00});
    expect_cmd(cmd_multi_purpose, -1, -1, -1, -1, -1, 42, -1);
    check_out();
    // Each broken sequence raises the sticky fault, cleared only by reset
    for (int i = 0; i < 7; i++) begin
      do_reset();
      cmp_level(8'(o_illegal), 8'h00);
      frame('{bad[i][0], bad[i][1], bad[i][2], bad[i][3]});
      repeat (8) @(negedge i_clock);
      cmp_level(8'(o_illegal), 8'h01);
    end
    finish_test();
  end
endmodule // dram_command_decode_timing_tb_top
`default_nettype wire
